// >>> rtl/board_housekeeping_regs.svh
// register offsets, field positions and timing counts of the housekeeping bank
// assumes a 40 ns clock period and 16-bit sequencer bus addresses
`ifndef BOARD_HOUSEKEEPING_REGS_SVH
`define BOARD_HOUSEKEEPING_REGS_SVH
// ==========================================================
// register offsets
`define ADDR_GLOBAL_EVENT 16'hFFF0
`define ADDR_INDICATOR_CTL 16'hFFF9
`define ADDR_SERIAL_NUM 16'hFFFA
`define ADDR_BOARD_TEMP 16'hFFFB
`define ADDR_MODE_CTL 16'hFFFC
`define ADDR_BOARD_STATUS 16'hFFFD
`define ADDR_IDENTITY 16'hFFFE
`define ADDR_FW_VERSION 16'hFFFF
`define ADDR_TELEM_BASE 16'h02E8
`define TELEM_CHANNELS 8
// ==========================================================
// field positions
`define EVT_NEW_IMAGE_BIT 15
`define EVT_FRAME_BIT 0
`define IND_FLASH_EN_BIT 0
`define TEMP_WIDTH 10
// ==========================================================
// timing
`define CLK_PERIOD_NS 40
`define CONV_WAIT_NS 35000
`define CONV_WAIT_CYC ((`CONV_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_MS 10
`define FLASH_CYC ((`FLASH_MS * 1000000) / `CLK_PERIOD_NS)
`define POR_MS 100
`define POR_CYC ((`POR_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_MS 30
`define BOOT_CYC ((`BOOT_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// >>> rtl/board_housekeeping_pkg.sv
// types shared by the housekeeping bank and its surroundings
// assumes the sequencer bus runs on the backplane clock
package board_housekeeping_pkg;
   // ==========================================================
   // sequencer bus request, one cycle strobes
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } bus_req_t;
   // sequencer raised events
   typedef struct packed {
      logic new_image;
      logic frame;
   } seq_event_t;
   // reset and boot sequencing
   typedef enum logic [1:0] {PWR_HOLD, BOOTING, RUNNING} boot_state_t;
endpackage : board_housekeeping_pkg

// >>> rtl/board_housekeeping_regs.sv
// housekeeping register bank: events, indicator, serial, temperature, ids, resets
// assumes sequencer bus strobes are synchronous to CLK; sensor pins are not
`timescale 1ns/100ps
`include "board_housekeeping_regs.svh"

module board_housekeeping_regs import board_housekeeping_pkg::*; #(
   parameter int unsigned POR_CYC = `POR_CYC,
   parameter int unsigned BOOT_CYC = `BOOT_CYC,
   parameter int unsigned FLASH_CYC = `FLASH_CYC,
   // arbitrary identity and version values
   parameter logic [15:0] BOARD_ID = 16'h5A3C,
   parameter logic [15:0] FW_VERSION = 16'h0064
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire bus_req_t BUS_REQ,
   input wire logic SEL_B,
   input wire seq_event_t SEQ_EVENT,
   input wire logic PANEL_RST_B,
   input wire logic [31:0] SERIAL_PIN,
   input wire logic [9:0] TEMP_PIN,
   input wire logic [15:0] TELEM_PIN,
   output logic [31:0] RDATA,
   output logic RVALID,
   output logic LED,
   output logic POWER_ON_RESET_PIN_N,
   output logic OUTPUT_EN,
   output logic SOFT_RESET,
   output logic TEMP_START,
   output logic TELEM_START,
   output logic [2:0] TELEM_CHAN
);
   localparam int CONV_CYC = `CONV_WAIT_CYC;
   localparam int SW = $clog2(POR_CYC + BOOT_CYC + 1);
   localparam int FW = $clog2(FLASH_CYC + 1);
   localparam int CVW = $clog2(CONV_CYC + 1);

   // address hits the telemetry channel window
   function automatic logic telem_hit(input logic [15:0] a);
      telem_hit = (a >= `ADDR_TELEM_BASE) && (a < `ADDR_TELEM_BASE + 16'h0008);
   endfunction : telem_hit

   // ==========================================================
   // pin synchronisers
   logic panel_s1_r, panel_s2_r;
   logic [31:0] serial_s1_r, serial_s2_r;
   logic [9:0] temp_s1_r, temp_s2_r;
   logic [15:0] telem_s1_r, telem_s2_r;

   // two flops on every pin from outside the clock domain
   always_ff @(posedge CLK) begin
      panel_s1_r <= PANEL_RST_B;
      panel_s2_r <= panel_s1_r;
      serial_s1_r <= SERIAL_PIN;
      serial_s2_r <= serial_s1_r;
      temp_s1_r <= TEMP_PIN;
      temp_s2_r <= temp_s1_r;
      telem_s1_r <= TELEM_PIN;
      telem_s2_r <= telem_s1_r;
   end

   // ==========================================================
   // reset and boot sequencing
   boot_state_t st_r;
   logic [SW-1:0] seq_cnt_r;
   logic running;
   logic wr_go, rd_go, reboot_go, hold_req;

   assign running = (st_r == RUNNING);
   assign hold_req = !panel_s2_r || reboot_go;

   // hold 100ms after supply good, then boot for 30ms
   always_ff @(posedge CLK) begin
      if (!RST_B || hold_req) begin
         st_r <= PWR_HOLD;
         seq_cnt_r <= '0;
      end else begin
         unique case (st_r)
            PWR_HOLD: begin
               if (seq_cnt_r == SW'(POR_CYC - 1)) begin
                  st_r <= BOOTING;
                  seq_cnt_r <= '0;
               end else begin
                  seq_cnt_r <= seq_cnt_r + 1'b1;
               end
            end
            BOOTING: begin
               if (seq_cnt_r == SW'(BOOT_CYC - 1)) begin
                  st_r <= RUNNING;
               end else begin
                  seq_cnt_r <= seq_cnt_r + 1'b1;
               end
            end
            RUNNING: seq_cnt_r <= '0;
         endcase
      end
   end

   // reset pin low while held; outputs only once running
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         POWER_ON_RESET_PIN_N <= 1'b0;
         OUTPUT_EN <= 1'b0;
      end else begin
         POWER_ON_RESET_PIN_N <= (st_r != PWR_HOLD) && !hold_req;
         OUTPUT_EN <= running && !hold_req;
      end
   end

   // ==========================================================
   // bus decode, every flop on the backplane clock
   assign wr_go = running && !SEL_B && BUS_REQ.wr;
   assign rd_go = running && !SEL_B && BUS_REQ.rd && !BUS_REQ.wr;
   assign reboot_go = wr_go && (BUS_REQ.addr == `ADDR_FW_VERSION);

   logic soft_go;
   assign soft_go = wr_go && (BUS_REQ.addr == `ADDR_IDENTITY);

   // soft reset pulse one cycle after the write
   always_ff @(posedge CLK) begin
      if (!RST_B || !running) begin
         SOFT_RESET <= 1'b0;
      end else begin
         SOFT_RESET <= soft_go;
      end
   end

   // ==========================================================
   // configuration registers, defaults on any hard reset
   logic [15:0] evt_r;
   logic flash_en_r;
   logic [15:0] mode_ctl_r;
   logic first_txn_r;

   // events: host write or sequencer, sequencer set wins
   always_ff @(posedge CLK) begin
      if (!RST_B || !running) begin
         evt_r <= 16'h0000;
      end else begin
         if (wr_go && BUS_REQ.addr == `ADDR_GLOBAL_EVENT) begin
            evt_r[`EVT_NEW_IMAGE_BIT] <= BUS_REQ.wdata[`EVT_NEW_IMAGE_BIT]
               || SEQ_EVENT.new_image;
            evt_r[`EVT_FRAME_BIT] <= BUS_REQ.wdata[`EVT_FRAME_BIT]
               || SEQ_EVENT.frame;
         end else begin
            evt_r[`EVT_NEW_IMAGE_BIT] <= evt_r[`EVT_NEW_IMAGE_BIT] || SEQ_EVENT.new_image;
            evt_r[`EVT_FRAME_BIT] <= evt_r[`EVT_FRAME_BIT] || SEQ_EVENT.frame;
         end
      end
   end

   // indicator and mode control; only bit 0 of indicator kept
   always_ff @(posedge CLK) begin
      if (!RST_B || !running) begin
         flash_en_r <= 1'b0;
         mode_ctl_r <= 16'h0000;
      end else if (wr_go) begin
         if (BUS_REQ.addr == `ADDR_INDICATOR_CTL) begin
            flash_en_r <= BUS_REQ.wdata[`IND_FLASH_EN_BIT];
         end
         if (BUS_REQ.addr == `ADDR_MODE_CTL) begin
            mode_ctl_r <= BUS_REQ.wdata[15:0];
         end
      end
   end

   // first valid transaction since power-up or reboot
   always_ff @(posedge CLK) begin
      if (!RST_B || !running) begin
         first_txn_r <= 1'b0;
      end else if (wr_go || rd_go) begin
         first_txn_r <= 1'b1;
      end
   end

   // ==========================================================
   // front panel indicator
   logic sel_b_prev_r;
   logic flash_go;
   logic [FW-1:0] flash_cnt_r;

   assign flash_go = running && first_txn_r && flash_en_r && !SEL_B && sel_b_prev_r;

   // select history for edge detection
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         sel_b_prev_r <= 1'b1;
      end else begin
         sel_b_prev_r <= SEL_B;
      end
   end

   // flash timer, idled by soft reset
   always_ff @(posedge CLK) begin
      if (!RST_B || !running || SOFT_RESET) begin
         flash_cnt_r <= '0;
      end else if (flash_go) begin
         flash_cnt_r <= FW'(FLASH_CYC);
      end else if (flash_cnt_r != '0) begin
         flash_cnt_r <= flash_cnt_r - 1'b1;
      end
   end

   // lit until first transaction, then only during a flash
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         LED <= 1'b1;
      end else begin
         LED <= !first_txn_r || (flash_cnt_r != '0);
      end
   end

   // ==========================================================
   // temperature conversion
   logic [CVW-1:0] temp_cnt_r;
   logic [9:0] temp_r;
   logic temp_go;

   assign temp_go = wr_go && (BUS_REQ.addr == `ADDR_BOARD_TEMP) && (temp_cnt_r == '0);

   // write starts, value captured once the wait has run out
   always_ff @(posedge CLK) begin
      if (!RST_B || !running || SOFT_RESET) begin
         temp_cnt_r <= '0;
         TEMP_START <= 1'b0;
      end else begin
         TEMP_START <= temp_go;
         if (temp_go) begin
            temp_cnt_r <= CVW'(CONV_CYC);
         end else if (temp_cnt_r != '0) begin
            temp_cnt_r <= temp_cnt_r - 1'b1;
         end
      end
   end

   // signed quarter-degree reading
   always_ff @(posedge CLK) begin
      if (!RST_B || !running) begin
         temp_r <= 10'h000;
      end else if (temp_cnt_r == CVW'(1)) begin
         temp_r <= temp_s2_r;
      end
   end

   // ==========================================================
   // supply telemetry, one result word per channel
   logic [15:0] telem_mem [`TELEM_CHANNELS];
   logic [CVW-1:0] telem_cnt_r;
   logic telem_go;

   assign telem_go = wr_go && telem_hit(BUS_REQ.addr) && (telem_cnt_r == '0);

   // conversion timer and channel latch
   always_ff @(posedge CLK) begin
      if (!RST_B || !running || SOFT_RESET) begin
         telem_cnt_r <= '0;
         TELEM_START <= 1'b0;
         TELEM_CHAN <= 3'h0;
      end else begin
         TELEM_START <= telem_go;
         if (telem_go) begin
            telem_cnt_r <= CVW'(CONV_CYC);
            TELEM_CHAN <= BUS_REQ.addr[2:0];
         end else if (telem_cnt_r != '0) begin
            telem_cnt_r <= telem_cnt_r - 1'b1;
         end
      end
   end

   // result lands in the addressed channel's word
   always_ff @(posedge CLK) begin
      if (!RST_B || !running) begin
         for (int i = 0; i < `TELEM_CHANNELS; i++) begin
            telem_mem[i] <= 16'h0000;
         end
      end else if (telem_cnt_r == CVW'(1)) begin
         telem_mem[TELEM_CHAN] <= telem_s2_r;
      end
   end

   // ==========================================================
   // read path
   logic [15:0] status;
   logic [31:0] rd_nxt;

   // live board state
   assign status = {10'h000, OUTPUT_EN, first_txn_r, flash_en_r,
                    (temp_cnt_r != '0), (telem_cnt_r != '0), LED};

   // read multiplexer, unmapped addresses read zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (telem_hit(BUS_REQ.addr)) begin
         rd_nxt = {16'h0000, telem_mem[BUS_REQ.addr[2:0]]};
      end else begin
         unique case (BUS_REQ.addr)
            `ADDR_GLOBAL_EVENT: rd_nxt = {16'h0000, evt_r};
            `ADDR_INDICATOR_CTL: rd_nxt = {31'h0000_0000, flash_en_r};
            `ADDR_SERIAL_NUM: rd_nxt = serial_s2_r;
            `ADDR_BOARD_TEMP: rd_nxt = {{22{temp_r[9]}}, temp_r};
            `ADDR_MODE_CTL: rd_nxt = {16'h0000, mode_ctl_r};
            `ADDR_BOARD_STATUS: rd_nxt = {16'h0000, status};
            `ADDR_IDENTITY: rd_nxt = {16'h0000, BOARD_ID};
            `ADDR_FW_VERSION: rd_nxt = {16'h0000, FW_VERSION};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         RDATA <= 32'h0000_0000;
         RVALID <= 1'b0;
      end else begin
         RVALID <= rd_go;
         if (rd_go) begin
            RDATA <= rd_nxt;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_id_read;
      rd_go && BUS_REQ.addr == `ADDR_IDENTITY;
   endsequence
   sequence s_reboot;
      reboot_go;
   endsequence
   sequence s_flash_start;
      flash_go;
   endsequence

   a_led_first_txn: assert property (!first_txn_r |=> LED)
      else $error("indicator dark before first transaction");
   a_flash_lit: assert property (s_flash_start |=> ##1 LED [*4])
      else $error("select flash not shown");
   a_temp_wait: assert property (TEMP_START |-> temp_cnt_r == CVW'(CONV_CYC))
      else $error("temperature wait count wrong");
   a_telem_wait: assert property (
      telem_go |=> TELEM_START && telem_cnt_r == CVW'(CONV_CYC))
      else $error("telemetry conversion not started");
   a_soft_keeps: assert property (
      soft_go |=> ##1 $stable(mode_ctl_r) && temp_cnt_r == '0)
      else $error("soft reset changed config");
   a_reboot_hold: assert property (
      s_reboot |=> st_r == PWR_HOLD ##1 !POWER_ON_RESET_PIN_N)
      else $error("reboot did not reset");
   a_panel_hold: assert property (!panel_s2_r |=> st_r == PWR_HOLD && !OUTPUT_EN)
      else $error("panel switch ignored");
   a_boot_outputs: assert property (st_r == BOOTING |=> !OUTPUT_EN)
      else $error("outputs enabled during boot");
   a_id_answer: assert property (s_id_read |=> RVALID && RDATA[15:0] == BOARD_ID)
      else $error("identity read wrong");
   a_evt_reserved: assert property (evt_r[14:1] == 14'h0000)
      else $error("undefined event bit set");
   a_por_length: assert property (
      $rose(st_r == BOOTING) |-> $past(seq_cnt_r) == SW'(POR_CYC - 1))
      else $error("power-on hold length wrong");
endmodule : board_housekeeping_regs

// >>> dv/sequencer_model.sv
// sequencer side of the backplane bus: board select, one-cycle strobes, events
// assumes CLK is the backplane clock; everything changes on its falling edge
`timescale 1ns/100ps

module sequencer_model import board_housekeeping_pkg::*; (
   input wire logic CLK,
   output bus_req_t BUS_REQ,
   output logic SEL_B,
   output seq_event_t SEQ_EVENT
);
   // ==========================================================
   // idle bus
   initial begin
      BUS_REQ = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 32'h0000_0000};
      SEL_B = 1'b1;
      SEQ_EVENT = '0;
   end

   // ==========================================================
   // one strobe with the board selected, then release the bus
   task automatic bus_cycle(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
      @(negedge CLK);
      SEL_B = 1'b0;
      BUS_REQ = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
      @(negedge CLK);
      SEL_B = 1'b1;
      // released lines do not keep the last value
      BUS_REQ = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
   endtask : bus_cycle

   // ==========================================================
   // one-cycle event pulse raised by the sequencer
   task automatic pulse(input seq_event_t ev);
      @(negedge CLK);
      SEQ_EVENT = ev;
      @(negedge CLK);
      SEQ_EVENT = '0;
   endtask : pulse
endmodule : sequencer_model

// >>> dv/testbench.sv
// self-checking bench for the housekeeping register bank
// assumes the sequencer model drives the bus; sensor pins are levels set by the main sequence
`timescale 1ns/100ps
`include "board_housekeeping_regs.svh"

module testbench import board_housekeeping_pkg::*;;
   localparam int POR = 20;
   localparam int BOOT = 10;
   localparam int FLASH = 16;
   // arbitrary identity value
   localparam logic [15:0] ID = 16'h3C96;
   localparam logic [15:0] VER = 16'h0193;
   logic CLK, RST_B, SEL_B, PANEL_RST_B;
   bus_req_t BUS_REQ;
   seq_event_t SEQ_EVENT;
   logic [31:0] SERIAL_PIN, RDATA;
   logic [9:0] TEMP_PIN;
   logic [15:0] TELEM_PIN;
   logic RVALID, LED, POWER_ON_RESET_PIN_N, OUTPUT_EN, SOFT_RESET, TEMP_START, TELEM_START;
   logic [2:0] TELEM_CHAN;
   int failures = 0;
   int total_checks = 0;
   int led_cnt = 0;
   int soft_cnt = 0;
   int temp_go_cnt = 0;
   int telem_go_cnt = 0;

   sequencer_model seq (.CLK(CLK), .BUS_REQ(BUS_REQ), .SEL_B(SEL_B), .SEQ_EVENT(SEQ_EVENT));

   board_housekeeping_regs #(.POR_CYC(POR), .BOOT_CYC(BOOT), .FLASH_CYC(FLASH),
      .BOARD_ID(ID), .FW_VERSION(VER)) dut (
      .CLK(CLK), .RST_B(RST_B), .BUS_REQ(BUS_REQ), .SEL_B(SEL_B), .SEQ_EVENT(SEQ_EVENT),
      .PANEL_RST_B(PANEL_RST_B), .SERIAL_PIN(SERIAL_PIN), .TEMP_PIN(TEMP_PIN),
      .TELEM_PIN(TELEM_PIN), .RDATA(RDATA), .RVALID(RVALID), .LED(LED),
      .POWER_ON_RESET_PIN_N(POWER_ON_RESET_PIN_N), .OUTPUT_EN(OUTPUT_EN),
      .SOFT_RESET(SOFT_RESET), .TEMP_START(TEMP_START), .TELEM_START(TELEM_START),
      .TELEM_CHAN(TELEM_CHAN));

   // ==========================================================
   // clock and pulse counters
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      if (LED === 1'b1) led_cnt++;
      if (SOFT_RESET === 1'b1) soft_cnt++;
      if (TEMP_START === 1'b1) temp_go_cnt++;
      if (TELEM_START === 1'b1) telem_go_cnt++;
   end

   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [15:0] addr, input logic [31:0] data);
      seq.bus_cycle(1'b1, addr, data);
   endtask : wr
   // answer stands for the cycle after the edge that takes the strobe
   task automatic rd(input string what, input logic [15:0] addr, input logic [31:0] exp);
      seq.bus_cycle(1'b0, addr, 32'h0000_0000);
      check("read answer", 32'h1, {31'h0, RVALID});
      check(what, exp, RDATA);
   endtask : rd
   // read compared through a mask, for registers with live bits
   task automatic rd_bits(input string what, input logic [15:0] addr, input logic [31:0] mask,
         input logic [31:0] exp);
      seq.bus_cycle(1'b0, addr, 32'h0000_0000);
      check(what, exp, RDATA & mask);
   endtask : rd_bits
   // edges from the call until outputs enable, against the hold and boot counts
   task automatic wait_boot(input int exp);
      int n;
      n = 0;
      while (OUTPUT_EN !== 1'b1 && n < 200) begin
         @(posedge CLK);
         #1;
         n++;
      end
      check("boot length", exp, n);
      check("reset released", 32'h1, {31'h0, POWER_ON_RESET_PIN_N});
      check("panel lit", 32'h1, {31'h0, LED});
      @(negedge CLK);
   endtask : wait_boot
   task automatic wait_conv();
      repeat (880) @(posedge CLK);
   endtask : wait_conv
   task automatic flash_count(input int exp);
      repeat (40) @(posedge CLK);
      led_cnt = 0;
      seq.bus_cycle(1'b0, `ADDR_MODE_CTL, 32'h0000_0000);
      repeat (40) @(posedge CLK);
      check("flash length", exp, led_cnt);
   endtask : flash_count
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #(40 * 20000);
      failures++;
      wrap_up();
   end

   // ==========================================================
   // main sequence
   initial begin
      RST_B = 1'b0;
      PANEL_RST_B = 1'b1;
      SERIAL_PIN = 32'hC3A5_1E70;
      TEMP_PIN = 10'h3F6;
      TELEM_PIN = 16'h0ABC;
      repeat (3) @(negedge CLK);
      check("reset pin", 32'h0, {31'h0, POWER_ON_RESET_PIN_N});
      RST_B = 1'b1;
      repeat (POR / 2) @(posedge CLK);
      #1;
      check("held reset", 32'h0, {31'h0, POWER_ON_RESET_PIN_N});
      wait_boot(POR + BOOT + 1 - POR / 2);
      rd("identity", `ADDR_IDENTITY, {16'h0, ID});
      rd("version", `ADDR_FW_VERSION, {16'h0, VER});
      rd("serial", `ADDR_SERIAL_NUM, SERIAL_PIN);
      wr(`ADDR_INDICATOR_CTL, 32'hFFFF_FFFF);
      rd("indicator", `ADDR_INDICATOR_CTL, 32'h1);
      flash_count(FLASH);
      wr(`ADDR_BOARD_STATUS, 32'h0000_0000);
      rd_bits("status", `ADDR_BOARD_STATUS, 32'hFFFF_FFF8, 32'h38);
      wr(`ADDR_INDICATOR_CTL, 32'h0000_0000);
      flash_count(0);
      // temperature: a write while busy is refused; later pin changes stay unseen
      wr(`ADDR_BOARD_TEMP, 32'h1234_5678);
      wr(`ADDR_BOARD_TEMP, 32'h0000_0000);
      wait_conv();
      check("temperature starts", 32'h1, temp_go_cnt);
      @(negedge CLK);
      TEMP_PIN = 10'h064;
      repeat (3) @(negedge CLK);
      rd("temperature", `ADDR_BOARD_TEMP, 32'hFFFF_FFF6);
      wr(16'h02EB, 32'h0000_0000);
      check("channel", 32'h3, {29'h0, TELEM_CHAN});
      wait_conv();
      check("telemetry starts", 32'h1, telem_go_cnt);
      rd("telemetry", 16'h02EB, 32'h0000_0ABC);
      wr(`ADDR_GLOBAL_EVENT, 32'hFFFF_FFFF);
      rd("events", `ADDR_GLOBAL_EVENT, 32'h8001);
      wr(`ADDR_GLOBAL_EVENT, 32'h0000_0000);
      seq.pulse('{new_image: 1'b1, frame: 1'b0});
      rd("event image", `ADDR_GLOBAL_EVENT, 32'h8000);
      seq.pulse('{new_image: 1'b0, frame: 1'b1});
      rd("event frame", `ADDR_GLOBAL_EVENT, 32'h8001);
      check("events inert", 32'h1, {31'h0, OUTPUT_EN});
      wr(`ADDR_MODE_CTL, 32'h0000_1234);
      rd("mode", `ADDR_MODE_CTL, 32'h1234);
      // soft reset idles a running conversion and keeps configuration
      wr(`ADDR_BOARD_TEMP, 32'h0000_0000);
      rd_bits("temperature busy", `ADDR_BOARD_STATUS, 32'h4, 32'h4);
      soft_cnt = 0;
      wr(`ADDR_IDENTITY, 32'h0000_0000);
      repeat (4) @(posedge CLK);
      check("soft pulses", 32'h1, soft_cnt);
      rd_bits("soft idle", `ADDR_BOARD_STATUS, 32'h4, 32'h0);
      rd("mode kept", `ADDR_MODE_CTL, 32'h1234);
      wr(`ADDR_FW_VERSION, 32'h0000_0000);
      repeat (3) @(posedge CLK);
      #1;
      check("reboot pin", 32'h0, {31'h0, POWER_ON_RESET_PIN_N});
      check("reboot outputs", 32'h0, {31'h0, OUTPUT_EN});
      wait_boot(POR + BOOT + 1 - 3);
      rd("events cleared", `ADDR_GLOBAL_EVENT, 32'h0);
      rd("mode default", `ADDR_MODE_CTL, 32'h0);
      @(negedge CLK);
      PANEL_RST_B = 1'b0;
      repeat (5) @(posedge CLK);
      #1;
      check("panel reset", 32'h0, {31'h0, POWER_ON_RESET_PIN_N});
      @(negedge CLK);
      PANEL_RST_B = 1'b1;
      wait_boot(POR + BOOT + 1 + 2);
      rd("after panel", `ADDR_IDENTITY, {16'h0, ID});
      wrap_up();
   end
endmodule : testbench
